// file: rtl/uart_pkg.sv
// Purpose: shared constants for the serial transmit/receive datapath
// Assumes: byte-addressed register port, one 8-bit register per word
// Notes:   parity helper is shared by transmitter and receiver
package uart_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 8;
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_BAUD    = 8'h04;
    localparam logic [7:0] OFS_TXBUF   = 8'h08;
    localparam logic [7:0] OFS_RXBUF   = 8'h0C;
    localparam logic [7:0] OFS_TXSTAT  = 8'h10;
    localparam logic [7:0] OFS_ERRSTAT = 8'h14;

    // ------------------------------------------------------------------
    // reset values and divisor minimum
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_RESET  = 8'h01;
    localparam logic [7:0] BAUD_RESET  = 8'hFF;
    localparam logic [7:0] RXBUF_RESET = 8'hFF;
    localparam logic [7:0] BAUD_MIN    = 8'h04;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MODE_POWER  = 7;
    localparam int MODE_TXEN   = 6;
    localparam int MODE_RXEN   = 5;
    localparam int MODE_PAR_HI = 4;
    localparam int MODE_PAR_LO = 3;
    localparam int MODE_CLEN8  = 2;
    localparam int MODE_STOP2  = 1;
    localparam int MODE_MERGE  = 0;
    localparam int TXST_FULL   = 1;
    localparam int TXST_SHIFT  = 0;
    localparam int ERR_PAR     = 2;
    localparam int ERR_FRAME   = 1;
    localparam int ERR_OVR     = 0;

    // ------------------------------------------------------------------
    // parity modes
    // ------------------------------------------------------------------
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // parity bit for a 7- or 8-bit character
    function automatic logic par_bit(input logic [7:0] d,
                                     input logic       eight,
                                     input logic [1:0] mode);
        logic ones;
        ones = ^(eight ? d : {1'b0, d[6:0]});
        case (mode)
            PAR_ODD:  par_bit = ~ones;
            PAR_EVEN: par_bit = ones;
            default:  par_bit = 1'b0;
        endcase
    endfunction : par_bit

endpackage : uart_pkg

// file: rtl/baud_tick.sv
// Purpose: half-bit tick divider, one per direction
// Assumes: divisor below the legal minimum is raised to it
// Notes:   counter sits at zero while not running
`timescale 1ns/10ps
`default_nettype none
module baud_tick #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt;
    logic [W-1:0] lim;

    assign lim  = (divisor < W'(uart_pkg::BAUD_MIN)) ?
                  W'(uart_pkg::BAUD_MIN) : divisor;
    assign tick = run && (cnt == lim - W'(1));

    always_ff @(posedge clk_sys) begin
        if (rst || !run || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + W'(1);
        end
    end
endmodule : baud_tick
`default_nettype wire

// file: rtl/uart_txrx_datapath.sv
// Purpose: asynchronous serial transmit and receive datapath
// Assumes: serial input synchronous to clk_sys; bit time is 2 x divisor
// Notes:   all outputs registered; interrupt lines are one-cycle pulses
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module uart_txrx_datapath (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       serial_input_pin,
    output logic            serial_output_pin,
    output logic            transmit_done_irq,
    output logic            receive_done_irq,
    output logic            receive_error_irq
);
    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

    logic [7:0]  serial_mode_register;
    logic [7:0]  baud_divisor_register;
    logic [7:0]  transmit_buffer;
    logic [11:0] transmit_shift_register;
    logic [7:0]  receive_shift_register;
    logic [7:0]  receive_buffer;
    logic [2:0]  receive_error_status;
    logic        buffer_full_flag;
    logic        shifting_flag;
    logic        tx_loaded;
    logic        rx_full;
    logic        rx_par;
    logic        rxd_q;
    logic        rxd_d;
    logic        tx_phase;
    logic        rx_phase;
    logic [3:0]  tx_left;
    logic [3:0]  rx_idx;
    tx_state_t   tx_state;
    rx_state_t   rx_state;
    logic        tx_tick;
    logic        rx_tick;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic       wr_mode, wr_baud, wr_txbuf, rd_rxbuf, rd_err;
    logic       power, tx_on, rx_on, clen8, stop2, merge, par_on;
    logic [1:0] par_mode;

    assign power    = serial_mode_register[uart_pkg::MODE_POWER];
    assign tx_on    = power && serial_mode_register[uart_pkg::MODE_TXEN];
    assign rx_on    = power && serial_mode_register[uart_pkg::MODE_RXEN];
    assign clen8    = serial_mode_register[uart_pkg::MODE_CLEN8];
    assign stop2    = serial_mode_register[uart_pkg::MODE_STOP2];
    assign merge    = serial_mode_register[uart_pkg::MODE_MERGE];
    assign par_mode = serial_mode_register[uart_pkg::MODE_PAR_HI:
                                           uart_pkg::MODE_PAR_LO];
    assign par_on   = par_mode != uart_pkg::PAR_NONE;

    always_comb begin
        wr_mode  = 1'b0;
        wr_baud  = 1'b0;
        wr_txbuf = 1'b0;
        rd_rxbuf = 1'b0;
        rd_err   = 1'b0;
        if (addr == uart_pkg::OFS_MODE) begin
            wr_mode = wr_en;
        end else if (addr == uart_pkg::OFS_BAUD) begin
            wr_baud = wr_en;
        end else if (addr == uart_pkg::OFS_TXBUF) begin
            wr_txbuf = wr_en;
        end else if (addr == uart_pkg::OFS_RXBUF) begin
            rd_rxbuf = rd_en;
        end else if (addr == uart_pkg::OFS_ERRSTAT) begin
            rd_err = rd_en;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_mode_register  <= uart_pkg::MODE_RESET;
            baud_divisor_register <= uart_pkg::BAUD_RESET;
        end else begin
            if (wr_mode) begin
                serial_mode_register <= wr_data;
            end
            if (wr_baud) begin
                baud_divisor_register <= wr_data;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst || !rd_en) begin
            rd_data <= 8'h00;
        end else if (addr == uart_pkg::OFS_MODE) begin
            rd_data <= serial_mode_register;
        end else if (addr == uart_pkg::OFS_BAUD) begin
            rd_data <= baud_divisor_register;
        end else if (addr == uart_pkg::OFS_TXBUF) begin
            rd_data <= transmit_buffer;
        end else if (addr == uart_pkg::OFS_RXBUF) begin
            rd_data <= receive_buffer;
        end else if (addr == uart_pkg::OFS_TXSTAT) begin
            rd_data <= {6'h00, buffer_full_flag, shifting_flag};
        end else if (addr == uart_pkg::OFS_ERRSTAT) begin
            rd_data <= {5'h00, receive_error_status};
        end else begin
            rd_data <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    baud_tick #(.W(8)) u_tx_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (tx_state == TX_SHIFT),
        .divisor (baud_divisor_register),
        .tick    (tx_tick)
    );

    logic        tx_load, tx_bit_end, tx_done;
    logic [11:0] tx_frame;
    logic [3:0]  tx_nbits;

    assign tx_load    = tx_on && tx_state == TX_IDLE && buffer_full_flag;
    assign tx_bit_end = tx_state == TX_SHIFT && tx_tick && tx_phase;
    assign tx_done    = tx_bit_end && tx_left == 4'h0;

    always_comb begin
        tx_frame    = 12'hFFF;
        tx_frame[0] = 1'b0;
        if (clen8) begin
            tx_frame[8:1] = transmit_buffer;
            tx_frame[9]   = par_on ? uart_pkg::par_bit(transmit_buffer,
                            1'b1, par_mode) : 1'b1;
        end else begin
            tx_frame[7:1] = transmit_buffer[6:0];
            tx_frame[8]   = par_on ? uart_pkg::par_bit(transmit_buffer,
                            1'b0, par_mode) : 1'b1;
        end
        tx_nbits = 4'h1 + (clen8 ? 4'h8 : 4'h7) + {3'h0, par_on}
                   + (stop2 ? 4'h2 : 4'h1);
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !tx_on) begin
            tx_state                <= TX_IDLE;
            serial_output_pin       <= 1'b1;
            transmit_shift_register <= 12'hFFF;
            tx_left                 <= 4'h0;
            tx_phase                <= 1'b0;
        end else if (tx_load) begin
            tx_state                <= TX_SHIFT;
            transmit_shift_register <= tx_frame;
            serial_output_pin       <= 1'b0;
            tx_left                 <= tx_nbits - 4'h1;
            tx_phase                <= 1'b0;
        end else if (tx_state == TX_SHIFT && tx_tick) begin
            tx_phase <= ~tx_phase;
            if (tx_done) begin
                tx_state <= TX_IDLE;
            end else if (tx_phase) begin
                transmit_shift_register <= {1'b1,
                    transmit_shift_register[11:1]};
                serial_output_pin <= transmit_shift_register[1];
                tx_left           <= tx_left - 4'h1;
            end
        end
    end

    // buffer frees one cycle after the load, giving the 11 window
    always_ff @(posedge clk_sys) begin
        if (rst || !tx_on) begin
            buffer_full_flag  <= 1'b0;
            shifting_flag     <= 1'b0;
            tx_loaded         <= 1'b0;
            transmit_done_irq <= 1'b0;
        end else begin
            tx_loaded         <= tx_load;
            transmit_done_irq <= tx_done;
            if (tx_load) begin
                shifting_flag <= 1'b1;
            end else if (tx_done) begin
                shifting_flag <= buffer_full_flag;
            end
            if (wr_txbuf) begin
                buffer_full_flag <= 1'b1;
            end else if (tx_loaded) begin
                buffer_full_flag <= 1'b0;
            end
        end
    end

    // writes while disabled are dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            transmit_buffer <= 8'h00;
        end else if (wr_txbuf && tx_on) begin
            transmit_buffer <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    baud_tick #(.W(8)) u_rx_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (rx_state != RX_IDLE),
        .divisor (baud_divisor_register),
        .tick    (rx_tick)
    );

    logic       rx_sample, rx_commit, rx_pe, rx_fe, rx_err;
    logic [3:0] rx_nchar, rx_last;
    logic [7:0] rx_word;

    assign rx_nchar  = clen8 ? 4'h8 : 4'h7;
    assign rx_last   = rx_nchar + {3'h0, par_on};
    assign rx_sample = rx_state == RX_DATA && rx_tick && rx_phase;
    assign rx_commit = rx_sample && rx_idx == rx_last;
    assign rx_word   = clen8 ? receive_shift_register :
                       {1'b0, receive_shift_register[6:0]};
    assign rx_fe     = !rxd_q;
    assign rx_pe     = (par_mode == uart_pkg::PAR_ODD ||
                        par_mode == uart_pkg::PAR_EVEN) &&
                       uart_pkg::par_bit(rx_word, clen8, par_mode)
                       != rx_par;
    assign rx_err    = rx_pe || rx_fe || rx_full;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxd_q <= 1'b1;
            rxd_d <= 1'b1;
        end else begin
            rxd_q <= serial_input_pin | ~power;
            rxd_d <= rxd_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !rx_on) begin
            rx_state               <= RX_IDLE;
            rx_phase               <= 1'b0;
            rx_idx                 <= 4'h0;
            rx_par                 <= 1'b0;
            receive_shift_register <= 8'h00;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (rxd_d && !rxd_q) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_state <= rxd_q ? RX_IDLE : RX_DATA;
                        rx_phase <= 1'b0;
                        rx_idx   <= 4'h0;
                    end
                end
                default: begin
                    if (rx_tick) begin
                        rx_phase <= ~rx_phase;
                    end
                    if (rx_sample) begin
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx < rx_nchar) begin
                            receive_shift_register[rx_idx[2:0]]
                                <= rxd_q;
                        end else if (!rx_commit) begin
                            rx_par <= rxd_q;
                        end
                        if (rx_commit) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // set beats the clearing read on every flag here
    always_ff @(posedge clk_sys) begin
        if (rst || !power) begin
            receive_buffer       <= uart_pkg::RXBUF_RESET;
            rx_full              <= 1'b0;
            receive_error_status <= 3'h0;
        end else begin
            if (rx_commit && !rx_full) begin
                receive_buffer <= rx_word;
            end
            rx_full <= (rx_full && !rd_rxbuf) || rx_commit;
            receive_error_status <=
                (rd_err ? 3'h0 : receive_error_status) |
                (rx_commit ? {rx_pe, rx_fe, rx_full} : 3'h0);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            receive_done_irq  <= 1'b0;
            receive_error_irq <= 1'b0;
        end else begin
            receive_done_irq  <= rx_commit && (!rx_err || merge);
            receive_error_irq <= rx_commit && rx_err && !merge;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_zero_par;
        rx_commit && !par_mode[1] && !rd_err |=>
            receive_error_status[uart_pkg::ERR_PAR] ==
            $past(receive_error_status[uart_pkg::ERR_PAR]);
    endproperty
    a_zero_par: assert property (p_zero_par)
        else $error("parity error flagged without parity check");

    property p_tx_gate;
        wr_txbuf && !tx_on |=> !buffer_full_flag ##1 !shifting_flag;
    endproperty
    a_tx_gate: assert property (p_tx_gate)
        else $error("write accepted while transmitter disabled");

    property p_start_bit;
        tx_load |=> !serial_output_pin && shifting_flag;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("frame did not begin with a low start bit");

    property p_flag_seq;
        wr_txbuf && tx_on && tx_state == TX_IDLE && !buffer_full_flag
            |=> (buffer_full_flag && !shifting_flag)
            ##1 (buffer_full_flag && shifting_flag)
            ##1 (!buffer_full_flag && shifting_flag);
    endproperty
    a_flag_seq: assert property (p_flag_seq)
        else $error("status flags did not step 10, 11, 01");

    property p_done_line;
        transmit_done_irq |-> serial_output_pin && $past(serial_output_pin)
            && $past(tx_state) == TX_SHIFT;
    endproperty
    a_done_line: assert property (p_done_line)
        else $error("transmit done not at end of stop bit");

    property p_idle_stay;
        tx_done && !buffer_full_flag && !wr_txbuf |=>
            !shifting_flag ##1 tx_state == TX_IDLE;
    endproperty
    a_idle_stay: assert property (p_idle_stay)
        else $error("transmitter did not go idle");

    property p_overrun;
        rx_commit && rx_full |=> receive_buffer == $past(receive_buffer)
            && receive_error_status[uart_pkg::ERR_OVR];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun overwrote receive buffer");

    property p_err_clear;
        rd_err && !rx_commit |=> receive_error_status == 3'h0;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error status not cleared by read");

    property p_split_irq;
        rx_commit && rx_err && !merge |=>
            receive_error_irq && !receive_done_irq;
    endproperty
    a_split_irq: assert property (p_split_irq)
        else $error("error not on separate interrupt");

    property p_merge_irq;
        rx_commit && rx_err && merge |=>
            receive_done_irq && !receive_error_irq;
    endproperty
    a_merge_irq: assert property (p_merge_irq)
        else $error("error not merged into receive done");

    property p_false_start;
        rx_state == RX_START && rx_tick && rxd_q |=> rx_state == RX_IDLE;
    endproperty
    a_false_start: assert property (p_false_start)
        else $error("high level accepted as start bit");

    c_back_to_back: cover property (tx_done && buffer_full_flag);
    c_rx_ok: cover property (rx_commit && !rx_err);
    c_rx_parity: cover property (rx_commit && rx_pe);
    c_overrun: cover property (rx_commit && rx_full);

endmodule : uart_txrx_datapath
`default_nettype wire

// file: verification/serial_node.sv
// Purpose: remote serial node on the far side of the line
// Assumes: 8 data bits plus one parity bit, bit time in clocks
// Notes:   line left high between frames, as an idle line is
`timescale 1ns/10ps
`default_nettype none
module serial_node #(
    parameter int BIT = 8
) (
    input  wire logic clk_sys,
    input  wire logic from_dut,
    output var logic  to_dut
);
    logic [10:0] got;
    initial to_dut = 1'b1;
    // start, data lsb first, parity, stop
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        logic [10:0] f;
        f = {s, p, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_sys) to_dut <= f[i];
            repeat (BIT - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys) to_dut <= 1'b1;
    endtask : send
    // low pulse shorter than half a bit, to be rejected as a start bit
    task automatic pulse(input int n);
        @(posedge clk_sys) to_dut <= 1'b0;
        repeat (n) @(posedge clk_sys);
        to_dut <= 1'b1;
    endtask : pulse
    // no wait after the stop sample, so a back-to-back start is caught
    task automatic take;
        @(negedge from_dut);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            #1 got[i] = from_dut;
            if (i < 10) repeat (BIT) @(posedge clk_sys);
        end
    endtask : take
endmodule : serial_node
`default_nettype wire

// file: verification/tb_uart_txrx_datapath.sv
// Purpose: register-level test of the serial datapath
// Assumes: divisor 4, so one bit lasts 8 clocks
// Notes:   irq pulses are counted, never sampled by the tests
`timescale 1ns/10ps
`default_nettype none
module tb_uart_txrx_datapath;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic [7:0]  rd_data;
    logic        line;
    logic        tx;
    logic        tdone;
    logic        rdone;
    logic        rerr;
    logic [10:0] f1;
    logic [10:0] f2;
    int          errors = 0;
    int          cmp_count = 0;
    int          n_done = 0;
    int          n_rx = 0;
    int          n_err = 0;
    always #50 clk_sys = ~clk_sys;
    uart_txrx_datapath dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .serial_input_pin(line), .serial_output_pin(tx),
        .transmit_done_irq(tdone), .receive_done_irq(rdone),
        .receive_error_irq(rerr));
    serial_node #(.BIT(8)) node (.clk_sys(clk_sys), .from_dut(tx),
        .to_dut(line));
    always @(posedge clk_sys) begin
        if (tdone === 1'b1) n_done++;
        if (rdone === 1'b1) n_rx++;
        if (rerr === 1'b1) n_err++;
    end
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys) wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys) rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys) rd_en <= 1'b0;
        #1 chk({3'h0, rd_data}, {3'h0, e});
    endtask : rd
    task automatic stop_test;
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(uart_pkg::OFS_MODE, uart_pkg::MODE_RESET);
        rd(uart_pkg::OFS_RXBUF, 8'hFF);
        wr(uart_pkg::OFS_BAUD, 8'h04);
        wr(uart_pkg::OFS_TXBUF, 8'h55);
        rd(uart_pkg::OFS_TXSTAT, 8'h00);
        wr(uart_pkg::OFS_MODE, 8'h80);
        wr(uart_pkg::OFS_MODE, 8'hFC);
        fork
            begin
                node.take();
                f1 = node.got;
                node.take();
                f2 = node.got;
            end
        join_none
        wr(uart_pkg::OFS_TXBUF, 8'h55);
        repeat (4) @(posedge clk_sys);
        rd(uart_pkg::OFS_TXSTAT, 8'h01);
        wr(uart_pkg::OFS_TXBUF, 8'h07);
        rd(uart_pkg::OFS_TXSTAT, 8'h03);
        repeat (200) @(posedge clk_sys);
        chk(f1, {2'b10, 8'h55, 1'b0});
        chk(f2, {2'b11, 8'h07, 1'b0});
        chk(11'(n_done), 11'h002);
        rd(uart_pkg::OFS_TXSTAT, 8'h00);
        node.send(8'hA5, 1'b0, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk(11'(n_rx), 11'h001);
        rd(uart_pkg::OFS_RXBUF, 8'hA5);
        node.send(8'hA5, 1'b1, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk(11'(n_err * 4 + n_rx), 11'h005);
        rd(uart_pkg::OFS_ERRSTAT, 8'h04);
        rd(uart_pkg::OFS_ERRSTAT, 8'h00);
        rd(uart_pkg::OFS_RXBUF, 8'hA5);
        node.send(8'h3C, 1'b0, 1'b1);
        node.send(8'hC3, 1'b0, 1'b1);
        repeat (2) @(posedge clk_sys);
        rd(uart_pkg::OFS_ERRSTAT, 8'h01);
        rd(uart_pkg::OFS_RXBUF, 8'h3C);
        wr(uart_pkg::OFS_MODE, 8'hED);
        node.send(8'h5A, 1'b1, 1'b1);
        repeat (2) @(posedge clk_sys);
        rd(uart_pkg::OFS_ERRSTAT, 8'h00);
        rd(uart_pkg::OFS_RXBUF, 8'h5A);
        node.send(8'h5A, 1'b0, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk(11'(n_err * 8 + n_rx), 11'h014);
        rd(uart_pkg::OFS_ERRSTAT, 8'h02);
        rd(uart_pkg::OFS_RXBUF, 8'h5A);
        rd(uart_pkg::OFS_TXSTAT, 8'h00);
        fork
            node.take();
        join_none
        wr(uart_pkg::OFS_TXBUF, 8'h7F);
        repeat (100) @(posedge clk_sys);
        chk(node.got, {2'b10, 8'h7F, 1'b0});
        chk(11'(n_done), 11'h003);
        rd(uart_pkg::OFS_TXSTAT, 8'h00);
        wr(uart_pkg::OFS_MODE, 8'hF2);
        fork
            node.take();
            node.send(8'hB6, 1'b1, 1'b1);
        join_none
        wr(uart_pkg::OFS_TXBUF, 8'h36);
        repeat (80) @(posedge clk_sys);
        rd(uart_pkg::OFS_TXSTAT, 8'h01);
        repeat (20) @(posedge clk_sys);
        chk(node.got, {3'b111, 7'h36, 1'b0});
        rd(uart_pkg::OFS_ERRSTAT, 8'h00);
        rd(uart_pkg::OFS_RXBUF, 8'h36);
        rd(uart_pkg::OFS_TXSTAT, 8'h00);
        wr(uart_pkg::OFS_MODE, 8'hE4);
        node.pulse(2);
        repeat (10) @(posedge clk_sys);
        fork
            node.take();
        join_none
        wr(uart_pkg::OFS_TXBUF, 8'h87);
        node.send(8'h87, 1'b1, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk(node.got, {2'b11, 8'h87, 1'b0});
        chk(11'(n_err + n_rx), 11'h008);
        rd(uart_pkg::OFS_ERRSTAT, 8'h00);
        rd(uart_pkg::OFS_RXBUF, 8'h87);
        stop_test();
    end
endmodule : tb_uart_txrx_datapath
`default_nettype wire
